// ### logic/scdsync_pkg.sv
package scdsync_pkg;
  // register map
  localparam logic [8:0] ALIGN_CTRL_ADDR = 9'h100;
  localparam logic [7:0] ALIGN_CTRL_RESET = 8'h00;
  localparam int ALIGN_EN_BIT = 1;
  localparam int ALIGN_ONCE_BIT = 2;
  // divider
  localparam int DIV_W = 3;
  localparam logic [2:0] DIV_INIT = 3'h0;
  // clock and restorer timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RELOCK_MIN_NS = 1500;
  localparam int RELOCK_MAX_NS = 5000;
  localparam int RELOCK_CYC = (RELOCK_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
    RELOCK_MAX_NS / CLK_PERIOD_NS;
  localparam int LOCK_W = 8;
  localparam int DCR_MIN_KHZ = 20000;
endpackage

// ### logic/scdsync_divider.sv
`timescale 1ns/1ps
module scdsync_divider #(
  parameter int W = scdsync_pkg::DIV_W
) (
  input wire logic clk, // sample clock
  input wire logic reset_n, // async reset, active low
  input wire logic [W-1:0] ratio_m1, // divide ratio minus one
  input wire logic realign, // return counter to initial state
  output logic [W-1:0] phase // current phase, 0 marks the rising edge
);
  logic [W-1:0] phase_reg;
  logic [W-1:0] phase_next;

  always_comb begin
    if (realign) begin
      phase_next = W'(scdsync_pkg::DIV_INIT); // [RULE_04]
    end else if (phase_reg >= ratio_m1) begin
      phase_next = W'(scdsync_pkg::DIV_INIT); // [RULE_01]
    end else begin
      phase_next = phase_reg + W'(1); // [RULE_01]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= W'(scdsync_pkg::DIV_INIT);
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;
endmodule // scdsync_divider

// ### logic/scdsync_top.sv
// Overview of operation
// [RULE_01] divide the sample clock by an integer ratio from one to eight
// [RULE_02] any ratio other than one forces the duty cycle restorer on
// [RULE_03] control bits 1 and 2 at 0x100 pick every-pulse or first-pulse realign
// [RULE_04] an accepted alignment pulse returns the divider counter to its start
// [RULE_05] active and locked restorer keeps rising edge, regenerates falling edge
// [RULE_06] restorer need not lock for input rates below about 20 MHz
// [RULE_07] clock source allows 1.5 to 5 us relock after a frequency change
// [RULE_08] while unlocked the input duty cycle passes through unmodified
// [RULE_09] keep the restorer enabled unless the clock rate changes dynamically
// [RULE_10] samples are captured on the rising edge of the divided clock
// [RULE_11] first-pulse mode re-arms on each control write, ignores pulses until then
`timescale 1ns/1ps
module scdsync_top #(
  parameter int IN_CLK_KHZ = 10000,
  parameter int RELOCK_CYCLES = scdsync_pkg::RELOCK_CYC
) (
  input wire logic clk, // sample clock
  input wire logic reset_n, // async reset, active low
  input wire logic [8:0] reg_addr, // register address
  input wire logic reg_wr, // register write strobe
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic [2:0] div_ratio_m1, // divide ratio minus one
  input wire logic dcr_enable, // restorer enable setting
  input wire logic align_pulse, // external alignment pulse
  output logic [7:0] reg_rdata, // register read data
  output logic conv_clk, // internal conversion clock
  output logic sample_strobe, // one-cycle pulse at each rising edge
  output logic dcr_active, // restorer switched on
  output logic dcr_locked, // restorer locked
  output logic align_armed // first-pulse mode waiting for a pulse
);
  localparam logic [scdsync_pkg::LOCK_W-1:0] RELOCK_LAST =
    scdsync_pkg::LOCK_W'(RELOCK_CYCLES);
  localparam bit RATE_OK = IN_CLK_KHZ >= scdsync_pkg::DCR_MIN_KHZ;

  logic [7:0] ctrl_reg, ctrl_next;
  logic armed_reg, armed_next;
  logic [2:0] ratio_seen_reg, ratio_seen_next;
  logic active_reg, active_next;
  logic [scdsync_pkg::LOCK_W-1:0] lock_cnt_reg, lock_cnt_next;
  logic locked_reg, locked_next;
  logic conv_reg, conv_next;
  logic strobe_reg, strobe_next;
  logic ctrl_wr, realign, dcr_want;
  logic [2:0] phase;
  logic align_en, align_once;

  function automatic logic [2:0] high_phases(input logic [2:0] r_m1);
    high_phases = 3'((4'(r_m1) + 4'h2) >> 1);
  endfunction

  assign ctrl_wr = reg_wr && (reg_addr == scdsync_pkg::ALIGN_CTRL_ADDR);
  assign dcr_want = dcr_enable || (div_ratio_m1 != 3'h0); // [RULE_02]
  assign align_en = ctrl_reg[scdsync_pkg::ALIGN_EN_BIT]; // [RULE_03]
  assign align_once = ctrl_reg[scdsync_pkg::ALIGN_ONCE_BIT]; // [RULE_03]

  // pulse policy: every pulse, or only the first one after a write
  always_comb begin
    realign = 1'b0;
    // the first-pulse bit only matters while realignment is enabled
    if (align_en) begin
      if (align_once) begin
        realign = align_pulse && armed_reg; // [RULE_11]
      end else begin
        realign = align_pulse; // [RULE_03]
      end
    end
  end

  always_comb begin
    ctrl_next = ctrl_wr ? reg_wdata : ctrl_reg; // [RULE_03]
    armed_next = armed_reg;
    if (realign) begin
      armed_next = 1'b0; // [RULE_11]
    end
    // a write landing with a pulse still re-arms, so the new setting is honoured
    if (ctrl_wr) begin
      armed_next = 1'b1; // [RULE_11]
    end
  end

  scdsync_divider #(.W(scdsync_pkg::DIV_W)) u_div (
    .clk(clk),
    .reset_n(reset_n),
    .ratio_m1(div_ratio_m1),
    .realign(realign),
    .phase(phase)
  );

  // restorer: any ratio or on/off change drops lock and restarts the wait
  always_comb begin
    ratio_seen_next = div_ratio_m1;
    active_next = dcr_want; // [RULE_02]
    lock_cnt_next = lock_cnt_reg;
    locked_next = locked_reg;
    if (!dcr_want || (div_ratio_m1 != ratio_seen_reg) || (dcr_want != active_reg)) begin
      lock_cnt_next = '0;
      locked_next = 1'b0; // [RULE_08]
    end else if (!RATE_OK) begin
      locked_next = 1'b0; // [RULE_06]
    end else if (lock_cnt_reg < RELOCK_LAST) begin
      lock_cnt_next = lock_cnt_reg + 1'b1; // [RULE_07]
    end else begin
      locked_next = 1'b1;
    end
  end

  // output clock shape; rising edge always on phase 0
  // limitation: shape is resolved to whole input cycles, so at ratio one the
  // output stays high and only sample_strobe marks each sampling edge
  always_comb begin
    strobe_next = (phase == scdsync_pkg::DIV_INIT); // [RULE_10]
    if (active_reg && locked_reg) begin
      conv_next = phase < high_phases(div_ratio_m1); // [RULE_05]
    end else begin
      // bypass: high for one input cycle, i.e. the input's own high phase
      conv_next = (phase == scdsync_pkg::DIV_INIT); // [RULE_08]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= scdsync_pkg::ALIGN_CTRL_RESET;
      armed_reg <= 1'b1;
      ratio_seen_reg <= 3'h0;
      active_reg <= 1'b0;
      lock_cnt_reg <= '0;
      locked_reg <= 1'b0;
      conv_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      armed_reg <= armed_next;
      ratio_seen_reg <= ratio_seen_next;
      active_reg <= active_next;
      lock_cnt_reg <= lock_cnt_next;
      locked_reg <= locked_next;
      conv_reg <= conv_next;
      strobe_reg <= strobe_next;
    end
  end

  assign reg_rdata = ctrl_reg;
  assign conv_clk = conv_reg;
  assign sample_strobe = strobe_reg;
  assign dcr_active = active_reg;
  assign dcr_locked = locked_reg;
  assign align_armed = armed_reg;

  // assertion helper: edges for which the restorer inputs have held still, saturating;
  // kept apart from the lock counter so lock timing is judged independently
  logic [scdsync_pkg::LOCK_W-1:0] quiet_cnt_reg, quiet_cnt_next;
  logic [2:0] ratio_prev_reg;
  logic want_prev_reg;

  always_comb begin
    quiet_cnt_next = quiet_cnt_reg;
    if (!dcr_want || (div_ratio_m1 != ratio_prev_reg) || (dcr_want != want_prev_reg)) begin
      quiet_cnt_next = '0;
    end else if (quiet_cnt_reg != '1) begin
      quiet_cnt_next = quiet_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_cnt_reg <= '0;
      ratio_prev_reg <= 3'h0;
      want_prev_reg <= 1'b0;
    end else begin
      quiet_cnt_reg <= quiet_cnt_next;
      ratio_prev_reg <= div_ratio_m1;
      want_prev_reg <= dcr_want;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_div_wrap: assert property ((phase >= div_ratio_m1) && !realign // [RULE_01]
    && $stable(div_ratio_m1) |=> phase == 3'h0)
    else $error("divider did not wrap at the ratio");
  a_div_bound: assert property ($stable(div_ratio_m1)[*2] |-> phase <= div_ratio_m1) // [RULE_01]
    else $error("divider phase beyond ratio");
  a_force_dcr: assert property ((div_ratio_m1 != 3'h0) |=> dcr_active) // [RULE_02]
    else $error("restorer not forced on for ratio above one");
  a_realign_init: assert property (realign |=> phase == 3'h0) // [RULE_04]
    else $error("accepted pulse did not reset divider");
  a_once_ignore: assert property (align_once && align_en && !armed_reg && !ctrl_wr // [RULE_11]
    |-> !realign)
    else $error("pulse accepted while disarmed");
  a_every_pulse: assert property (align_en && !align_once && align_pulse |-> realign) // [RULE_03]
    else $error("pulse ignored in every-pulse mode");
  a_rearm_write: assert property (ctrl_wr |=> align_armed && reg_rdata == $past(reg_wdata)) // [RULE_11]
    else $error("write did not store or re-arm");
  a_strobe_edge: assert property (phase == 3'h0 |=> sample_strobe && conv_clk) // [RULE_10]
    else $error("rising edge missing at phase zero");
  a_bypass_unlock: assert property (!locked_reg && phase != 3'h0 |=> !conv_clk) // [RULE_08]
    else $error("output reshaped while unlocked");
  a_no_lock_slow: assert property (!RATE_OK |-> !dcr_locked) // [RULE_06]
    else $error("restorer locked below minimum rate");
  a_lock_wait: assert property ($rose(dcr_locked) |-> quiet_cnt_reg >= RELOCK_LAST) // [RULE_07]
    else $error("lock before relock wait elapsed");
  a_lock_within: assert property (RATE_OK && (quiet_cnt_reg > RELOCK_LAST) // [RULE_07]
    |-> dcr_locked)
    else $error("restorer failed to lock after the relock wait");
  a_duty_fall: assert property (active_reg && locked_reg && (div_ratio_m1 != 3'h0) // [RULE_05]
    && (phase == (div_ratio_m1 >> 1) + 3'h1) |=> !conv_clk)
    else $error("falling edge not regenerated at half period");
  a_enable_on: assert property (dcr_enable |=> dcr_active) // [RULE_02]
    else $error("restorer not on while enabled");
  a_restorer_off: assert property (!dcr_enable && (div_ratio_m1 == 3'h0) // [RULE_02]
    |=> !dcr_active)
    else $error("restorer on with ratio one and enable clear");
  a_div_step: assert property ((phase < div_ratio_m1) && !realign // [RULE_01]
    |=> phase == $past(phase) + 3'h1)
    else $error("divider phase did not advance by one");
  a_disarm_hold: assert property (!align_armed && !ctrl_wr |=> !align_armed) // [RULE_11]
    else $error("armed without a control write");

  c_realign: cover property (realign ##1 phase == 3'h0);
  c_once_drop: cover property (armed_reg && realign ##[1:16] align_pulse && !realign);
  c_slow_fall: cover property (locked_reg && div_ratio_m1 == 3'h7 && $fell(conv_clk));
  c_lock: cover property ($rose(dcr_locked));
  c_div8: cover property (div_ratio_m1 == 3'h7 && phase == 3'h7);
endmodule // scdsync_top

// ### testbench/scdsync_src.sv
`timescale 1ns/1ps
module scdsync_src (
  input wire logic clk, // sample clock
  input wire logic fire, // request one alignment pulse
  output logic align_pulse // one-cycle alignment pulse
);
  // launched a cycle after the request, so the pulse is clean at the sampling edge
  always_ff @(posedge clk) begin
    align_pulse <= fire;
  end
endmodule // scdsync_src

// ### testbench/sample_clock_divider_sync_test.sv
`timescale 1ns/1ps
module sample_clock_divider_sync_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [2:0] div_ratio_m1 = 3'h0;
  logic dcr_enable = 1'b0;
  logic fire = 1'b0;
  logic align_pulse, conv_clk, sample_strobe, dcr_active, dcr_locked, align_armed;
  logic [7:0] reg_rdata;
  logic slow_locked;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  initial begin
    forever #50 clk = ~clk;
  end
  scdsync_src i_scdsync_src (.clk(clk), .fire(fire), .align_pulse(align_pulse));
  // fast input rate and short relock so the lock path is reached quickly
  scdsync_top #(.IN_CLK_KHZ(20000), .RELOCK_CYCLES(4)) i_scdsync_top (.clk(clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .div_ratio_m1(div_ratio_m1), .dcr_enable(dcr_enable), .align_pulse(align_pulse),
    .reg_rdata(reg_rdata), .conv_clk(conv_clk), .sample_strobe(sample_strobe),
    .dcr_active(dcr_active), .dcr_locked(dcr_locked), .align_armed(align_armed));
  // default input rate sits below the restorer's floor, so this copy must never lock
  scdsync_top #(.RELOCK_CYCLES(4)) i_scdsync_top_slow (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .div_ratio_m1(div_ratio_m1),
    .dcr_enable(dcr_enable), .align_pulse(align_pulse), .reg_rdata(), .conv_clk(),
    .sample_strobe(), .dcr_active(), .dcr_locked(slow_locked), .align_armed());
  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic seek(output int c);
    c = 0;
    do begin
      step(1);
      c++;
    end while (sample_strobe !== 1'b1 && c < 20);
    if (sample_strobe !== 1'b1) begin
      chk(1'b0, "strobe timeout");
      summarize();
    end
  endtask
  task automatic period(input int k);
    @(posedge clk);
    div_ratio_m1 <= 3'(k - 1);
    step(3);
    seek(n);
    seek(n);
    chk(n == k, "divide period");
  endtask
  task automatic highs(input int k);
    n = 0;
    repeat (k) begin
      step(1);
      if (conv_clk === 1'b1) n++;
    end
  endtask
  task automatic align_chk(input logic e);
    // sync to a strobe first, so a refused pulse cannot meet the natural edge
    seek(n);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    // pulse taken at the next edge, which loads phase 0; strobe shown one edge after that
    step(2);
    chk(sample_strobe === e, "realign strobe");
  endtask
  initial begin
    step(10);
    chk(reg_rdata === scdsync_pkg::ALIGN_CTRL_RESET, "reset rdata");
    chk(align_armed === 1'b1, "reset armed");
    @(posedge clk);
    reset_n <= 1'b1;
    step(2);
    chk(dcr_active === 1'b0, "restorer off");
    @(posedge clk);
    dcr_enable <= 1'b1;
    step(2);
    chk(dcr_active === 1'b1, "restorer enabled");
    @(posedge clk);
    dcr_enable <= 1'b0;
    div_ratio_m1 <= 3'h7;
    step(2);
    chk(dcr_active === 1'b1, "restorer forced");
    for (int k = 1; k <= 8; k++) period(k);
    @(posedge clk);
    div_ratio_m1 <= 3'h0;
    step(4);
    @(posedge clk);
    div_ratio_m1 <= 3'h3;
    step(1);
    highs(4);
    chk(n == 1, "unlocked passthrough");
    n = 0;
    while (dcr_locked !== 1'b1 && n < 30) begin
      step(1);
      n++;
    end
    chk(dcr_locked === 1'b1, "no lock");
    if (dcr_locked !== 1'b1) summarize();
    chk(slow_locked === 1'b0, "slow clock locked");
    highs(4);
    chk(n == 2, "restored duty");
    @(posedge clk);
    div_ratio_m1 <= 3'h7;
    wr(scdsync_pkg::ALIGN_CTRL_ADDR, 8'h02);
    chk(reg_rdata === 8'h02, "write readback");
    align_chk(1'b1);
    align_chk(1'b1);
    wr(9'h0ff, 8'hff);
    chk(reg_rdata === 8'h02, "unmapped write");
    wr(scdsync_pkg::ALIGN_CTRL_ADDR, 8'h00);
    align_chk(1'b0);
    wr(scdsync_pkg::ALIGN_CTRL_ADDR, 8'h06);
    chk(align_armed === 1'b1, "armed");
    align_chk(1'b1);
    chk(align_armed === 1'b0, "disarmed");
    align_chk(1'b0);
    wr(scdsync_pkg::ALIGN_CTRL_ADDR, 8'h06);
    chk(align_armed === 1'b1, "rearmed");
    align_chk(1'b1);
    summarize();
  end
endmodule // sample_clock_divider_sync_test
